/* File: rtl/midi_uart_host_port.sv */
// Purpose: MIDI host port with command interpreter, two FIFOs and interrupt.
// Assumes: Host strobes are one-cycle pulses synchronous to ref_clk_in.
// Notes:   Two I/O ports, no other bus.
// Contract
// - Ten-bit decode, two ports, no aliasing.
// - Data at offset zero, command/status at one.
// - Separate 16-byte transmit and receive FIFOs.
// - Serial rate fixed at 31.25 kbaud.
// - One start, eight data, one stop.
// - Status bit 7 shows receive FIFO empty.
// - Status bit 6 shows transmit FIFO full.
// - Status low six bits echo last command.
// - Every receive FIFO push raises interrupt.
// - Data port read clears the interrupt.
// - Reset enters non-UART mode.
// - Non-UART: data writes dropped, reads last byte.
// - 3Fh enters UART mode, acknowledges FEh.
// - Listed commands push FEh and reply.
// - Other non-UART commands push FEh only.
// - UART mode: data writes queue and transmit.
// - UART reads pop; full FIFO overwrites last.
// - FFh returns to non-UART mode.
// - Other UART-mode commands are ignored; the code still records them in the status echo.

`include "midi_uart_defs.svh"

module midi_uart_host_port #(
    parameter int BIT_CYCLES = `MIDI_BIT_CYCLES
) (
    input  wire logic                    ref_clk_in,
    input  wire logic                    rstn_in,
    input  wire logic [`MIDI_DEC_TOP:0]  midi_port_base_in,
    input  wire midi_uart_pkg::host_req_t host_req_in,
    output logic [7:0]                   rd_data_out,
    output logic                         rd_valid_out,
    output logic                         irq_out,
    output logic                         midi_serial_out,
    input  wire logic                    midi_serial_in
);
    import midi_uart_pkg::*;

    localparam logic [`MIDI_CNT_W-1:0] FIFO_FULL = `MIDI_CNT_W'(`MIDI_FIFO_DEPTH);

    // Mode state.
    mode_t                    mode;
    logic [7:0]               last_cmd;
    logic [7:0]               last_pushed;

    // FIFO storage.
    logic [7:0]               rx_mem [`MIDI_FIFO_DEPTH];
    logic [7:0]               tx_mem [`MIDI_FIFO_DEPTH];
    logic [`MIDI_PTR_W-1:0]   rx_wr;
    logic [`MIDI_PTR_W-1:0]   rx_rd;
    logic [`MIDI_CNT_W-1:0]   rx_cnt;
    logic [`MIDI_PTR_W-1:0]   tx_wr;
    logic [`MIDI_PTR_W-1:0]   tx_rd;
    logic [`MIDI_CNT_W-1:0]   tx_cnt;

    // Reply queue.
    logic [7:0]               ack_q0;
    logic [7:0]               ack_q1;
    logic [1:0]               ack_cnt;
    logic                     ser_pend;
    logic [7:0]               ser_byte;

    // Strobes and controls.
    logic                     hit;
    logic                     data_rd;
    logic                     data_wr;
    logic                     cmd_wr;
    logic                     stat_rd;
    logic                     rx_empty;
    logic                     tx_full;
    logic                     push_en;
    logic [7:0]               push_byte;
    logic                     push_ack;
    logic                     rx_pop;
    logic                     rx_flush;
    logic                     rx_over;
    logic                     tx_push;
    logic                     tx_pop;

    // Engine handshake.
    logic                     eng_ready;
    logic                     eng_rx_valid;
    logic [7:0]               eng_rx_data;
    logic [`MIDI_PTR_W-1:0]   rx_wr_at;

    // Upper bits must be zero and the block sits on an eight-location boundary.
    assign hit = (host_req_in.addr[`MIDI_ADDR_W-1:`MIDI_DEC_TOP+1] == '0)
              && (host_req_in.addr[`MIDI_DEC_TOP:`MIDI_ALIGN_LSB]
                  == midi_port_base_in[`MIDI_DEC_TOP:`MIDI_ALIGN_LSB])
              && (host_req_in.addr[`MIDI_ALIGN_LSB-1:1] == '0);

    // Offset zero is the data port, offset one command (write) or status (read).
    assign data_rd = hit && host_req_in.rd && (host_req_in.addr[0] == `MIDI_OFS_DATA);
    assign data_wr = hit && host_req_in.wr && (host_req_in.addr[0] == `MIDI_OFS_DATA);
    assign stat_rd = hit && host_req_in.rd && (host_req_in.addr[0] == `MIDI_OFS_CMD_STAT);
    assign cmd_wr  = hit && host_req_in.wr && (host_req_in.addr[0] == `MIDI_OFS_CMD_STAT);

    // Flags come from the fill counts.
    assign rx_empty = (rx_cnt == '0);
    assign tx_full  = (tx_cnt == FIFO_FULL);

    // Acknowledges go first; a serial byte waits, since it arrives only every ten bits.
    always_comb begin
        push_ack  = (ack_cnt != 2'd0);
        push_en   = push_ack || ser_pend;
        push_byte = push_ack ? ack_q0 : ser_byte;
    end

    // Reads pop in UART mode; in non-UART mode they show the last byte and flush.
    assign rx_pop   = data_rd && (mode == UART_MODE) && !rx_empty;
    assign rx_flush = data_rd && (mode == NON_UART);
    // Overwrite only when nothing leaves in the same cycle.
    assign rx_over  = push_en && (rx_cnt == FIFO_FULL) && !rx_pop && !rx_flush;
    // Overwrite lands on the newest entry.
    assign rx_wr_at = rx_over ? rx_wr - 1'b1 : rx_wr;

    // Host data writes are queued only in UART mode and only while room remains.
    assign tx_push = data_wr && (mode == UART_MODE) && !tx_full;
    assign tx_pop  = eng_ready && (tx_cnt != '0);

    // Operating mode, switched only by the enter and leave codes.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode <= NON_UART;
        end else if (cmd_wr) begin
            if (mode == NON_UART && host_req_in.data == `MIDI_CMD_ENTER) begin
                mode <= UART_MODE;
            end else if (mode == UART_MODE && host_req_in.data == `MIDI_CMD_LEAVE) begin
                mode <= NON_UART;
                // Other codes keep the mode.
            end
        end
    end

    // Every command byte is remembered for the status echo, in either mode.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            last_cmd <= `MIDI_CMD_RESET;
        end else if (cmd_wr) begin
            last_cmd <= host_req_in.data;
        end
    end

    // Acknowledge queue: up to two bytes per command, drained one per cycle.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ack_q0  <= `MIDI_BYTE_RESET;
            ack_q1  <= `MIDI_BYTE_RESET;
            ack_cnt <= 2'd0;
        end else if (cmd_wr && mode == NON_UART) begin
            // A new command drops queued replies.
            ack_q0  <= `MIDI_ACK;
            ack_cnt <= 2'd2;
            if (host_req_in.data >= `MIDI_CMD_ZERO_LO && host_req_in.data <= `MIDI_CMD_ZERO_HI) begin
                ack_q1 <= `MIDI_REPLY_ZERO;
            end else begin
                case (host_req_in.data)
                    `MIDI_CMD_AB: ack_q1 <= `MIDI_REPLY_ZERO;
                    `MIDI_CMD_AC: ack_q1 <= `MIDI_REPLY_AC;
                    `MIDI_CMD_AD: ack_q1 <= `MIDI_REPLY_AD;
                    `MIDI_CMD_AF: ack_q1 <= `MIDI_REPLY_AF;
                    default:      ack_cnt <= 2'd1;
                endcase
            end
        end else if (push_ack) begin
            // One reply leaves per cycle.
            ack_q0  <= ack_q1;
            ack_cnt <= ack_cnt - 2'd1;
        end
    end

    // Serial bytes are held until the push port is free; arrival wins over drain.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ser_pend <= 1'b0;
            ser_byte <= `MIDI_BYTE_RESET;
        end else if (eng_rx_valid && mode == UART_MODE) begin
            // One holding byte covers ten bits.
            ser_pend <= 1'b1;
            ser_byte <= eng_rx_data;
        end else if (ser_pend && !push_ack) begin
            ser_pend <= 1'b0;
        end
    end

    // Receive FIFO storage; a full FIFO rewrites its newest entry.
    always_ff @(posedge ref_clk_in) begin
        if (push_en) begin
            rx_mem[rx_wr_at] <= push_byte;
        end
    end

    // Receive FIFO pointers and fill count.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_wr  <= '0;
            rx_rd  <= '0;
            rx_cnt <= '0;
        end else begin
            if (push_en && !rx_over) begin
                rx_wr <= rx_wr + 1'b1;
            end
            // A byte pushed with a flush survives.
            if (rx_flush) begin
                rx_rd  <= rx_wr;
                rx_cnt <= (push_en && !rx_over) ? `MIDI_CNT_W'(1) : '0;
            end else begin
                if (rx_pop) begin
                    rx_rd <= rx_rd + 1'b1;
                end
                // Pushes and pops net out.
                rx_cnt <= rx_cnt + `MIDI_CNT_W'(push_en && !rx_over) - `MIDI_CNT_W'(rx_pop);
            end
        end
    end

    // Newest byte placed in the receive buffer, shown by non-UART reads.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            last_pushed <= `MIDI_BYTE_RESET;
        end else if (push_en) begin
            last_pushed <= push_byte;
        end
    end

    // Transmit FIFO storage.
    always_ff @(posedge ref_clk_in) begin
        if (tx_push) begin
            tx_mem[tx_wr] <= host_req_in.data;
        end
    end

    // Transmit FIFO pointers; the engine drains one byte each time it goes idle.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_wr  <= '0;
            tx_rd  <= '0;
            tx_cnt <= '0;
        end else begin
            // A full FIFO refuses the write.
            if (tx_push) begin
                tx_wr <= tx_wr + 1'b1;
            end
            if (tx_pop) begin
                tx_rd <= tx_rd + 1'b1;
            end
            tx_cnt <= tx_cnt + `MIDI_CNT_W'(tx_push) - `MIDI_CNT_W'(tx_pop);
        end
    end

    // Interrupt: a push sets it even in the cycle a data read would clear it.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_out <= 1'b0;
        end else if (push_en) begin
            irq_out <= 1'b1;
        end else if (data_rd) begin
            irq_out <= 1'b0;
        end
    end

    // Read data is registered and valid for one cycle after the read strobe.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_data_out  <= `MIDI_BYTE_RESET;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= data_rd || stat_rd;
            // Both flags and the command echo.
            if (stat_rd) begin
                rd_data_out[`MIDI_STAT_RXE_BIT]    <= rx_empty;
                rd_data_out[`MIDI_STAT_TXF_BIT]    <= tx_full;
                rd_data_out[`MIDI_STAT_CMD_W-1:0]  <= last_cmd[`MIDI_STAT_CMD_W-1:0];
            end else if (rx_pop) begin
                rd_data_out <= rx_mem[rx_rd];
            end else if (data_rd) begin
                // Empty UART-mode reads also fall back to the newest byte.
                rd_data_out <= last_pushed;
            end
        end
    end

    // Idle engine pops the transmit FIFO.
    midi_serial_engine #(
        .BIT_CYCLES (BIT_CYCLES)
    ) engine (
        .ref_clk_in      (ref_clk_in),
        .rstn_in         (rstn_in),
        .tx_valid_in     (tx_cnt != '0),
        .tx_data_in      (tx_mem[tx_rd]),
        .tx_ready_out    (eng_ready),
        .midi_serial_out (midi_serial_out),
        .midi_serial_in  (midi_serial_in),
        .rx_valid_out    (eng_rx_valid),
        .rx_data_out     (eng_rx_data)
    );

endmodule

/* File: rtl/midi_uart_defs.svh */
// Purpose: Constants for the MIDI host port: offsets, fields, codes, timing.
// Assumes: Included by its bare name from the package and design files.
// Notes:   Definitions only.
`ifndef MIDI_UART_DEFS_SVH
`define MIDI_UART_DEFS_SVH

// Port offsets within the two-location block.
`define MIDI_OFS_DATA      1'b0
`define MIDI_OFS_CMD_STAT  1'b1

// Address decode: ten decoded bits, block aligned to eight locations.
`define MIDI_ADDR_W        16
`define MIDI_DEC_TOP       9
`define MIDI_ALIGN_LSB     3

// Status field positions.
`define MIDI_STAT_RXE_BIT  7
`define MIDI_STAT_TXF_BIT  6
`define MIDI_STAT_CMD_W    6

// FIFO geometry.
`define MIDI_FIFO_DEPTH    16
`define MIDI_PTR_W         4
`define MIDI_CNT_W         5

// Reset values.
`define MIDI_CMD_RESET     8'h00
`define MIDI_BYTE_RESET    8'h00

// Command and acknowledge codes.
`define MIDI_CMD_ENTER     8'h3F
`define MIDI_CMD_LEAVE     8'hFF
`define MIDI_CMD_ZERO_LO   8'hA0
`define MIDI_CMD_ZERO_HI   8'hA7
`define MIDI_CMD_AB        8'hAB
`define MIDI_CMD_AC        8'hAC
`define MIDI_CMD_AD        8'hAD
`define MIDI_CMD_AF        8'hAF
`define MIDI_ACK           8'hFE
`define MIDI_REPLY_ZERO    8'h00
`define MIDI_REPLY_AC      8'h15
`define MIDI_REPLY_AD      8'h01
`define MIDI_REPLY_AF      8'h64

// Serial timing: 31.25 kbaud from a 4 ns clock.
`define MIDI_CLK_PERIOD_NS 4
`define MIDI_BIT_TIME_NS   32000
`define MIDI_BIT_CYCLES    (`MIDI_BIT_TIME_NS / `MIDI_CLK_PERIOD_NS)
`define MIDI_BIT_CNT_W     16
`define MIDI_DATA_BITS     8

`endif

/* File: rtl/midi_uart_pkg.sv */
// Purpose: Types shared by the MIDI host port and its serial engine.
// Assumes: Constants come from the defs header.
// Notes:   Types only.
`include "midi_uart_defs.svh"

package midi_uart_pkg;

    // One host I/O cycle, valid for the single clock it is presented.
    typedef struct packed {
        logic                     rd;
        logic                     wr;
        logic [`MIDI_ADDR_W-1:0]  addr;
        logic [7:0]               data;
    } host_req_t;

    typedef enum logic { NON_UART, UART_MODE } mode_t;

    typedef enum logic [1:0] { RX_IDLE, RX_START, RX_DATA, RX_STOP } rx_state_t;

    typedef enum logic { TX_IDLE, TX_SHIFT } tx_state_t;

endpackage

/* File: rtl/midi_serial_engine.sv */
// Purpose: 8N1 serial transmitter and receiver for the MIDI link.
// Assumes: The serial input is already synchronous to ref_clk_in.
// Notes:   Framing errors drop the character silently.
`include "midi_uart_defs.svh"

module midi_serial_engine #(
    parameter int BIT_CYCLES = `MIDI_BIT_CYCLES
) (
    input  wire logic       ref_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       tx_valid_in,
    input  wire logic [7:0] tx_data_in,
    output logic            tx_ready_out,
    output logic            midi_serial_out,
    input  wire logic       midi_serial_in,
    output logic            rx_valid_out,
    output logic [7:0]      rx_data_out
);
    import midi_uart_pkg::*;

    localparam logic [`MIDI_BIT_CNT_W-1:0] BIT_LAST  = `MIDI_BIT_CNT_W'(BIT_CYCLES - 1);
    localparam logic [`MIDI_BIT_CNT_W-1:0] HALF_LAST = `MIDI_BIT_CNT_W'(BIT_CYCLES / 2 - 1);

    tx_state_t                    tx_state;
    logic [`MIDI_BIT_CNT_W-1:0]   tx_cnt;
    logic [3:0]                   tx_bits;
    logic [8:0]                   tx_sh;
    rx_state_t                    rx_state;
    logic [`MIDI_BIT_CNT_W-1:0]   rx_cnt;
    logic [2:0]                   rx_bits;
    logic [7:0]                   rx_sh;
    logic                         rx_prev;

    // A byte is taken only while the line is idle.
    assign tx_ready_out = (tx_state == TX_IDLE);

    // Transmitter: start bit, eight data bits LSB first, one stop bit.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_state        <= TX_IDLE;
            tx_cnt          <= '0;
            tx_bits         <= '0;
            tx_sh           <= '1;
            midi_serial_out <= 1'b1;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    midi_serial_out <= 1'b1;
                    if (tx_valid_in) begin
                        tx_sh           <= {1'b1, tx_data_in};
                        midi_serial_out <= 1'b0;
                        tx_bits         <= '0;
                        tx_cnt          <= '0;
                        tx_state        <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (tx_cnt == BIT_LAST) begin
                        tx_cnt <= '0;
                        if (tx_bits == 4'd9) begin
                            tx_state <= TX_IDLE;
                        end else begin
                            midi_serial_out <= tx_sh[0];
                            tx_sh           <= {1'b1, tx_sh[8:1]};
                            tx_bits         <= tx_bits + 4'd1;
                        end
                    end else begin
                        tx_cnt <= tx_cnt + 1'b1;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // Receiver: a falling edge starts a character; bits are sampled mid-cell.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_state     <= RX_IDLE;
            rx_cnt       <= '0;
            rx_bits      <= '0;
            rx_sh        <= '0;
            rx_prev      <= 1'b1;
            rx_valid_out <= 1'b0;
            rx_data_out  <= `MIDI_BYTE_RESET;
        end else begin
            rx_prev      <= midi_serial_in;
            rx_valid_out <= 1'b0;
            case (rx_state)
                RX_IDLE: begin
                    rx_cnt <= '0;
                    if (rx_prev && !midi_serial_in) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_cnt == HALF_LAST) begin
                        rx_cnt   <= '0;
                        rx_bits  <= '0;
                        // A glitch shorter than half a bit is not a start.
                        rx_state <= midi_serial_in ? RX_IDLE : RX_DATA;
                    end else begin
                        rx_cnt <= rx_cnt + 1'b1;
                    end
                end
                RX_DATA: begin
                    if (rx_cnt == BIT_LAST) begin
                        rx_cnt  <= '0;
                        rx_sh   <= {midi_serial_in, rx_sh[7:1]};
                        rx_bits <= rx_bits + 3'd1;
                        if (rx_bits == 3'd7) begin
                            rx_state <= RX_STOP;
                        end
                    end else begin
                        rx_cnt <= rx_cnt + 1'b1;
                    end
                end
                RX_STOP: begin
                    if (rx_cnt == BIT_LAST) begin
                        rx_cnt   <= '0;
                        rx_state <= RX_IDLE;
                        if (midi_serial_in) begin
                            rx_valid_out <= 1'b1;
                            rx_data_out  <= rx_sh;
                        end
                    end else begin
                        rx_cnt <= rx_cnt + 1'b1;
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

endmodule

/* File: sim/midi_uart_host_port_chk.sv */
// Purpose: Port-level assertions for the MIDI host port.
// Assumes: Bound to the top module; reset is asynchronous, active low.
// Notes:   Serial checks need BIT_CYCLES of eight or more.
`include "midi_uart_defs.svh"

module midi_uart_host_port_chk #(
    parameter int BIT_CYCLES = 16
) (
    input wire logic                     ref_clk_in,
    input wire logic                     rstn_in,
    input wire logic [`MIDI_DEC_TOP:0]   midi_port_base_in,
    input wire midi_uart_pkg::host_req_t host_req_in,
    input wire logic [7:0]               rd_data_out,
    input wire logic                     rd_valid_out,
    input wire logic                     irq_out,
    input wire logic                     midi_serial_out,
    input wire logic                     midi_serial_in
);
    import midi_uart_pkg::*;
    logic       dec;
    logic [7:0] last_cmd;
    // Decode mirrors the ten-bit, no-alias rule so that a loose decoder shows up.
    assign dec = host_req_in.addr[15:10] == 6'h0 && host_req_in.addr[2:1] == 2'h0
        && host_req_in.addr[9:3] == midi_port_base_in[9:3];
    // Shadow of the last command byte, for the status echo.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            last_cmd <= 8'h00;
        else if (host_req_in.wr && dec && host_req_in.addr[0])
            last_cmd <= host_req_in.data;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    a_read_answer: assert property (host_req_in.rd && dec |=> rd_valid_out)
        else $error("decoded read not answered");
    a_no_alias: assert property (host_req_in.rd && !dec |=> !rd_valid_out)
        else $error("foreign address answered");
    a_valid_cause: assert property (rd_valid_out |-> $past(host_req_in.rd && dec))
        else $error("read strobe without a read");
    a_write_silent: assert property (host_req_in.wr |=> !rd_valid_out)
        else $error("write produced read strobe");
    a_status_echo: assert property (host_req_in.rd && dec && host_req_in.addr[0]
        |=> rd_data_out[5:0] == last_cmd[5:0]) else $error("status low bits wrong");
    a_data_hold: assert property (!rd_valid_out |-> $stable(rd_data_out))
        else $error("read data moved without a read");
    a_rx_flag: assert property (irq_out && host_req_in.rd && dec && host_req_in.addr[0]
        |=> !rd_data_out[7]) else $error("empty flag set while data pending");
    a_irq_clear: assert property ($fell(irq_out)
        |-> $past(host_req_in.rd && dec && !host_req_in.addr[0])) else $error("irq fell alone");
    a_start_bit: assert property ($fell(midi_serial_out) |-> !midi_serial_out [*8])
        else $error("start bit too short");
endmodule

bind midi_uart_host_port midi_uart_host_port_chk #(.BIT_CYCLES(BIT_CYCLES)) chk_i (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .midi_port_base_in(midi_port_base_in),
    .host_req_in(host_req_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .irq_out(irq_out), .midi_serial_out(midi_serial_out), .midi_serial_in(midi_serial_in));

/* File: sim/midi_link_partner.sv */
// Purpose: Behavioural MIDI instrument at the far end of the serial link.
// Assumes: One bit lasts BIT_CYCLES clocks; the line idles high.
// Notes:   Heard frames are queued for the bench to compare.
module midi_link_partner #(
    parameter int BIT_CYCLES = 16
) (
    input  wire logic ref_clk_in,
    input  wire logic line_in,
    output logic      line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] heard_q[$];
    int         bad_stop = 0;
    logic [7:0] sh;
    initial line_out = 1'b1;
    // Receive at mid-bit, least significant bit first; a low stop bit is counted.
    initial begin
        forever begin
            @(negedge line_in);
            repeat (BIT_CYCLES / 2) @(posedge ref_clk_in);
            repeat (8) begin
                repeat (BIT_CYCLES) @(posedge ref_clk_in);
                sh = {line_in, sh[7:1]};
            end
            repeat (BIT_CYCLES) @(posedge ref_clk_in);
            if (line_in !== 1'b1)
                bad_stop++;
            heard_q.push_back(sh);
        end
    end
    // Send one frame: start, eight data bits, stop, then the line rests high.
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        repeat (10) begin
            line_out = f[0];
            f = f >> 1;
            repeat (BIT_CYCLES) @(negedge ref_clk_in);
        end
    endtask
endmodule

/* File: sim/tb_midi_uart_host_port.sv */
// Purpose: Self-checking bench for the MIDI host port.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Short bit time keeps serial scenarios brief.
`include "midi_uart_defs.svh"

module tb_midi_uart_host_port;
    timeunit 1ns;
    timeprecision 1ps;
    import midi_uart_pkg::*;
    localparam int         BITC = 16;
    localparam logic [9:0] BASE = 10'h330;
    logic       ref_clk_in = 1'b0;
    logic       rstn_in = 1'b0;
    logic       rx_line, tx_line, rd_valid_out, irq_out;
    logic [7:0] rd_data_out, got;
    host_req_t  req = '0;
    int         error_cnt = 0, tests_run = 0, cyc = 0;
    // Clock at 250 MHz.
    always #2 ref_clk_in = ~ref_clk_in;
    midi_uart_host_port #(.BIT_CYCLES(BITC)) midi_uart_host_port_i (
        .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .midi_port_base_in(BASE),
        .host_req_in(req), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
        .irq_out(irq_out), .midi_serial_out(tx_line), .midi_serial_in(rx_line));
    midi_link_partner #(.BIT_CYCLES(BITC)) midi_link_partner_i (
        .ref_clk_in(ref_clk_in), .line_in(tx_line), .line_out(rx_line));
    function automatic logic [15:0] ad(input logic [2:0] o);
        return {6'h00, BASE[9:3], o};
    endfunction
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One-cycle strobe; the answer is taken in the next cycle, while rd_valid_out stands.
    task automatic bus(input logic r, input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk_in);
        req = '{rd: r, wr: !r, addr: a, data: d};
        @(negedge ref_clk_in);
        req = '0;
        got = rd_data_out;
        if (r)
            cmp({7'h0, rd_valid_out}, {7'h0, a[15:10] == 6'h00});
    endtask
    task automatic pause(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    task automatic t_reset();
        bus(1, ad(1), 8'h00);
        cmp(got, 8'h80);
        cmp({7'h0, irq_out}, 8'h00);
    endtask
    task automatic t_commands();
        logic [7:0] c[9] = '{8'hA0, 8'hA7, 8'hAB, 8'hAC, 8'hAD, 8'hAF, 8'h12, 8'hFF, 8'hA8};
        logic [7:0] r[9] = '{8'h00, 8'h00, 8'h00, 8'h15, 8'h01, 8'h64, 8'hFE, 8'hFE, 8'hFE};
        for (int i = 0; i < 9; i++) begin
            bus(0, ad(1), c[i]);
            pause(4);
            cmp({7'h0, irq_out}, 8'h01);
            bus(1, ad(1), 8'h00);
            cmp(got, {2'b00, c[i][5:0]});
            bus(1, ad(0), 8'h00);
            cmp(got, r[i]);
            cmp({7'h0, irq_out}, 8'h00);
        end
        bus(0, ad(0), 8'h55);
        pause(BITC * 12);
        cmp(8'(midi_link_partner_i.heard_q.size()), 8'h00);
    endtask
    task automatic t_enter();
        bus(0, ad(1) | 16'h0400, 8'h3F);
        pause(4);
        cmp({7'h0, irq_out}, 8'h00);
        bus(1, ad(1) | 16'h0400, 8'h00);
        bus(0, ad(1), 8'h3F);
        pause(4);
        bus(1, ad(0), 8'h00);
        cmp(got, 8'hFE);
        bus(0, ad(1), 8'h12);
        pause(4);
        cmp({7'h0, irq_out}, 8'h00);
        bus(1, ad(1), 8'h00);
        cmp(got, 8'h92);
    endtask
    task automatic t_transmit();
        for (int i = 0; i < 18; i++)
            bus(0, ad(0), 8'(8'h20 + i));
        bus(1, ad(1), 8'h00);
        cmp(got, 8'hD2);
        pause(17 * 10 * BITC + 100);
        cmp(8'(midi_link_partner_i.heard_q.size()), 8'd17);
        for (int i = 0; i < 17; i++)
            cmp(midi_link_partner_i.heard_q[i], 8'(8'h20 + i));
        cmp(8'(midi_link_partner_i.bad_stop), 8'h00);
        bus(1, ad(1), 8'h00);
        cmp(got, 8'h92);
    endtask
    task automatic t_receive();
        for (int i = 0; i < 18; i++)
            midi_link_partner_i.send(8'(8'h40 + i));
        pause(8);
        cmp({7'h0, irq_out}, 8'h01);
        for (int i = 0; i < 16; i++) begin
            bus(1, ad(0), 8'h00);
            cmp(got, (i < 15) ? 8'(8'h40 + i) : 8'h51);
        end
        cmp({7'h0, irq_out}, 8'h00);
        bus(1, ad(1), 8'h00);
        cmp(got, 8'h92);
    endtask
    task automatic t_leave();
        bus(0, ad(1), 8'hFF);
        pause(4);
        cmp({7'h0, irq_out}, 8'h00);
        bus(0, ad(1), 8'h12);
        pause(4);
        bus(1, ad(0), 8'h00);
        cmp(got, 8'hFE);
    endtask
    task automatic test_done();
        $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // A hang is cut short well beyond the expected run of some 6100 cycles.
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 15000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        pause(4);
        rstn_in = 1'b1;
        t_reset();
        t_commands();
        t_enter();
        t_transmit();
        t_receive();
        t_leave();
        test_done();
    end
endmodule
